// File: design/prf_pkg.sv
// Purpose: Shared constants for the process RAM transfer engine.
// Assumes: Byte addressed host register port, 10 address bits.
// Notes: Offsets are byte addresses of 32-bit registers.
package prf_pkg;

  // Host port geometry.
  localparam int HOST_AW = 10;
  localparam int CORE_AW = 16;

  // Register offsets.
  localparam logic [HOST_AW-1:0] REG_RD_ADDR_LEN = 10'h308;
  localparam logic [HOST_AW-1:0] REG_RD_CMD = 10'h30C;
  localparam logic [HOST_AW-1:0] REG_WR_ADDR_LEN = 10'h310;
  localparam logic [HOST_AW-1:0] REG_WR_CMD = 10'h314;

  // Data FIFO windows: 000h-01Ch read data, 020h-03Ch write data.
  localparam int FIFO_WIN_LSB = 5;
  localparam logic [HOST_AW-1:FIFO_WIN_LSB] RD_FIFO_WIN = 5'h00;
  localparam logic [HOST_AW-1:FIFO_WIN_LSB] WR_FIFO_WIN = 5'h01;

  // Field positions.
  localparam int LEN_LSB = 16;
  localparam int LEN_W = 16;
  localparam int PTR_W = 16;
  localparam int CMD_BUSY_BIT = 31;
  localparam int CMD_ABORT_BIT = 30;
  localparam int CMD_CNT_LSB = 8;
  localparam int CMD_AVAIL_BIT = 0;

  // FIFO shape and reset values.
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int LVL_W = 5;
  localparam logic [LVL_W-1:0] WR_FREE_RESET = 5'h10;
  localparam logic [31:0] ADDR_LEN_RESET = 32'h00000000;
  localparam logic [1:0] LAST_LANE = 2'h3;

endpackage

// File: design/prf_fifo.sv
// Purpose: Word FIFO with valid and ready on both sides and a flush.
// Assumes: DEPTH is two to the power AW; one clock, synchronous reset.
// Notes: Read data come straight from the storage registers.
`timescale 1ns/1ps
module prf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int LW = 5
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LW-1:0] level
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [LW-1:0] count_reg, count_next;
  logic push, pop;

  assign in_ready = (count_reg != LW'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign level = count_reg;

  always_comb begin
    push = in_valid && in_ready && !flush;
    pop = out_valid && out_ready && !flush;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (flush) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next = '0;
    end else begin
      if (push) begin
        wr_ptr_next = wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_next = rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_next = count_reg + LW'(1);
      end else if (pop && !push) begin
        count_next = count_reg - LW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // Storage needs no reset; the count hides stale words.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

endmodule

// File: design/prf_engine.sv
// Purpose: Moves bytes between the core process RAM and host data FIFOs.
// Assumes: Core port takes one byte request at a time and acks it later.
// Notes: Reads have priority on the core port when both engines wait.
`timescale 1ns/1ps
module prf_engine import prf_pkg::*; (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RST,
  // Host register port.
  input wire logic HOST_WR,
  input wire logic HOST_RD,
  input wire logic [HOST_AW-1:0] HOST_ADDR,
  input wire logic [31:0] HOST_WDATA,
  output logic [31:0] HOST_RDATA,
  output logic HOST_RVALID,
  // Core process RAM byte port.
  output logic CORE_REQ,
  output logic CORE_WE,
  output logic [CORE_AW-1:0] CORE_ADDR,
  output logic [7:0] CORE_WDATA,
  input wire logic CORE_ACK,
  input wire logic [7:0] CORE_RDATA
);

  logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next, wr_ptr_reg, wr_ptr_next;
  logic [LEN_W-1:0] rd_len_reg, rd_len_next, wr_len_reg, wr_len_next;
  logic rd_busy_reg, rd_busy_next, wr_busy_reg, wr_busy_next;
  logic rd_abort_reg, rd_abort_next, wr_abort_reg, wr_abort_next;
  logic [31:0] rd_asm_reg, rd_asm_next, wr_buf_reg, wr_buf_next;
  logic rd_asm_full_reg, rd_asm_full_next, wr_buf_valid_reg, wr_buf_valid_next;
  logic pend_reg, pend_next, pend_wr_reg, pend_wr_next;
  logic [1:0] pend_lane_reg, pend_lane_next;
  logic core_req_reg, core_req_next, core_we_reg, core_we_next;
  logic [CORE_AW-1:0] core_addr_reg, core_addr_next;
  logic [7:0] core_wdata_reg, core_wdata_next;
  logic [31:0] host_rdata_reg, host_rdata_next;
  logic host_rvalid_reg, host_rvalid_next;
  logic rd_cmd_wr, wr_cmd_wr, rd_al_wr, wr_al_wr;
  logic rd_start, rd_cancel, wr_start, wr_cancel;
  logic rd_want, wr_want, rd_ack, wr_ack;
  logic rd_in_ready, rd_out_valid, rd_pop, wr_in_ready, wr_out_valid, wr_pop, wr_push;
  logic [31:0] rd_out_data, wr_out_data;
  logic [LVL_W-1:0] rd_level, wr_level, wr_free;
  logic [HOST_AW-1:FIFO_WIN_LSB] win;
  // Host decode.
  always_comb begin
    win = HOST_ADDR[HOST_AW-1:FIFO_WIN_LSB];
    rd_cmd_wr = HOST_WR && (HOST_ADDR == REG_RD_CMD);
    wr_cmd_wr = HOST_WR && (HOST_ADDR == REG_WR_CMD);
    rd_al_wr = HOST_WR && (HOST_ADDR == REG_RD_ADDR_LEN);
    wr_al_wr = HOST_WR && (HOST_ADDR == REG_WR_ADDR_LEN);
    // A zero in busy or abort is simply not decoded as a command.
    rd_cancel = rd_cmd_wr && HOST_WDATA[CMD_ABORT_BIT];
    wr_cancel = wr_cmd_wr && HOST_WDATA[CMD_ABORT_BIT];
    rd_start = rd_cmd_wr && HOST_WDATA[CMD_BUSY_BIT] && !rd_cancel && !rd_busy_reg;
    wr_start = wr_cmd_wr && HOST_WDATA[CMD_BUSY_BIT] && !wr_cancel && !wr_busy_reg;
    rd_pop = HOST_RD && (win == RD_FIFO_WIN) && (HOST_ADDR[1:0] == 2'h0) && rd_out_valid;
    wr_push = HOST_WR && (win == WR_FIFO_WIN) && (HOST_ADDR[1:0] == 2'h0);
    wr_free = LVL_W'(FIFO_DEPTH) - wr_level;
    rd_want = rd_busy_reg && (rd_len_reg != '0) && !rd_asm_full_reg && !rd_cancel;
    wr_want = wr_busy_reg && wr_buf_valid_reg && (wr_len_reg != '0) && !wr_cancel;
    rd_ack = CORE_ACK && pend_reg && !pend_wr_reg && rd_busy_reg && !rd_cancel;
    wr_ack = CORE_ACK && pend_reg && pend_wr_reg && wr_busy_reg && !wr_cancel;
    wr_pop = wr_busy_reg && !wr_buf_valid_reg && (wr_len_reg != '0) && !wr_cancel;
  end

  // Read data FIFO: stalls the fetch engine when full, so no byte is lost.
  prf_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW), .LW(LVL_W)) u_rd_fifo (
    .clk(SYS_CLK),
    .rst(RST),
    .flush(rd_cancel),
    .in_valid(rd_asm_full_reg),
    .in_ready(rd_in_ready),
    .in_data(rd_asm_reg),
    .out_valid(rd_out_valid),
    .out_ready(rd_pop),
    .out_data(rd_out_data),
    .level(rd_level)
  );

  // Write data FIFO: a host word that finds it full is dropped.
  prf_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW), .LW(LVL_W)) u_wr_fifo (
    .clk(SYS_CLK),
    .rst(RST),
    .flush(wr_cancel),
    .in_valid(wr_push),
    .in_ready(wr_in_ready),
    .in_data(HOST_WDATA),
    .out_valid(wr_out_valid),
    .out_ready(wr_pop),
    .out_data(wr_out_data),
    .level(wr_level)
  );

  always_comb begin
    rd_ptr_next = rd_ptr_reg;
    rd_len_next = rd_len_reg;
    rd_busy_next = rd_busy_reg;
    rd_asm_next = rd_asm_reg;
    rd_asm_full_next = rd_asm_full_reg;
    wr_ptr_next = wr_ptr_reg;
    wr_len_next = wr_len_reg;
    wr_busy_next = wr_busy_reg;
    wr_buf_next = wr_buf_reg;
    wr_buf_valid_next = wr_buf_valid_reg;
    rd_abort_next = rd_cancel;
    wr_abort_next = wr_cancel;
    pend_next = pend_reg;
    pend_wr_next = pend_wr_reg;
    pend_lane_next = pend_lane_reg;
    core_req_next = 1'b0;
    core_we_next = core_we_reg;
    core_addr_next = core_addr_reg;
    core_wdata_next = core_wdata_reg;

    // An ack always retires the request, even one that an abort orphaned.
    if (CORE_ACK && pend_reg) begin
      pend_next = 1'b0;
    end
    if (rd_ack) begin
      rd_asm_next[pend_lane_reg*8 +: 8] = CORE_RDATA;
      rd_len_next = rd_len_reg - LEN_W'(1);
      rd_ptr_next = rd_ptr_reg + PTR_W'(1);
      if ((pend_lane_reg == LAST_LANE) || (rd_len_reg == LEN_W'(1))) begin
        rd_asm_full_next = 1'b1;
      end
    end
    if (wr_ack) begin
      wr_len_next = wr_len_reg - LEN_W'(1);
      wr_ptr_next = wr_ptr_reg + PTR_W'(1);
      if ((pend_lane_reg == LAST_LANE) || (wr_len_reg == LEN_W'(1))) begin
        wr_buf_valid_next = 1'b0;
      end
    end

    // Assembled word leaves for the read FIFO.
    if (rd_asm_full_reg && rd_in_ready) begin
      rd_asm_full_next = 1'b0;
      rd_asm_next = '0;
    end
    if (wr_pop && wr_out_valid) begin
      wr_buf_next = wr_out_data;
      wr_buf_valid_next = 1'b1;
    end

    // One byte request at a time; fetches win the core port.
    if (!pend_reg && rd_want) begin
      core_req_next = 1'b1;
      core_we_next = 1'b0;
      core_addr_next = rd_ptr_reg;
      pend_next = 1'b1;
      pend_wr_next = 1'b0;
      pend_lane_next = rd_ptr_reg[1:0];
    end else if (!pend_reg && wr_want) begin
      core_req_next = 1'b1;
      core_we_next = 1'b1;
      core_addr_next = wr_ptr_reg;
      core_wdata_next = wr_buf_reg[wr_ptr_reg[1:0]*8 +: 8];
      pend_next = 1'b1;
      pend_wr_next = 1'b1;
      pend_lane_next = wr_ptr_reg[1:0];
    end

    // Completion once nothing is left to move.
    if (rd_busy_reg && (rd_len_reg == '0) && !rd_asm_full_reg &&
        !(pend_reg && !pend_wr_reg)) begin
      rd_busy_next = 1'b0;
    end
    if (wr_busy_reg && (wr_len_reg == '0) && !(pend_reg && pend_wr_reg)) begin
      wr_busy_next = 1'b0;
    end

    if (rd_cancel) begin
      rd_busy_next = 1'b0;
      rd_asm_next = '0;
      rd_asm_full_next = 1'b0;
    end else if (rd_start) begin
      rd_busy_next = 1'b1;
      rd_asm_next = '0;
      rd_asm_full_next = 1'b0;
    end
    if (wr_cancel) begin
      wr_busy_next = 1'b0;
      wr_buf_valid_next = 1'b0;
    end else if (wr_start) begin
      wr_busy_next = 1'b1;
      wr_buf_valid_next = 1'b0;
    end

    // Host stores win over engine updates; legal only while idle.
    if (rd_al_wr) begin
      rd_len_next = HOST_WDATA[LEN_LSB +: LEN_W];
      rd_ptr_next = HOST_WDATA[PTR_W-1:0];
    end
    if (wr_al_wr) begin
      wr_len_next = HOST_WDATA[LEN_LSB +: LEN_W];
      wr_ptr_next = HOST_WDATA[PTR_W-1:0];
    end
  end

  // Host read answer, one cycle after the strobe.
  always_comb begin
    host_rvalid_next = HOST_RD;
    host_rdata_next = '0;
    if (HOST_RD) begin
      if (rd_pop) begin
        host_rdata_next = rd_out_data;
      end else if (HOST_ADDR == REG_RD_ADDR_LEN) begin
        host_rdata_next = {rd_len_reg, rd_ptr_reg};
      end else if (HOST_ADDR == REG_WR_ADDR_LEN) begin
        host_rdata_next = {wr_len_reg, wr_ptr_reg};
      end else if (HOST_ADDR == REG_RD_CMD) begin
        host_rdata_next[CMD_BUSY_BIT] = rd_busy_reg;
        host_rdata_next[CMD_ABORT_BIT] = rd_abort_reg;
        host_rdata_next[CMD_CNT_LSB +: LVL_W] = rd_level;
        host_rdata_next[CMD_AVAIL_BIT] = (rd_level != '0);
      end else if (HOST_ADDR == REG_WR_CMD) begin
        host_rdata_next[CMD_BUSY_BIT] = wr_busy_reg;
        host_rdata_next[CMD_ABORT_BIT] = wr_abort_reg;
        host_rdata_next[CMD_CNT_LSB +: LVL_W] = wr_free;
        host_rdata_next[CMD_AVAIL_BIT] = (wr_free != '0);
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rd_ptr_reg <= ADDR_LEN_RESET[PTR_W-1:0];
      rd_len_reg <= ADDR_LEN_RESET[LEN_LSB +: LEN_W];
      wr_ptr_reg <= ADDR_LEN_RESET[PTR_W-1:0];
      wr_len_reg <= ADDR_LEN_RESET[LEN_LSB +: LEN_W];
      rd_busy_reg <= 1'b0;
      wr_busy_reg <= 1'b0;
      rd_abort_reg <= 1'b0;
      wr_abort_reg <= 1'b0;
      rd_asm_reg <= '0;
      rd_asm_full_reg <= 1'b0;
      wr_buf_reg <= '0;
      wr_buf_valid_reg <= 1'b0;
      pend_reg <= 1'b0;
      pend_wr_reg <= 1'b0;
      pend_lane_reg <= '0;
      core_req_reg <= 1'b0;
      core_we_reg <= 1'b0;
      core_addr_reg <= '0;
      core_wdata_reg <= '0;
      host_rdata_reg <= '0;
      host_rvalid_reg <= 1'b0;
    end else begin
      rd_ptr_reg <= rd_ptr_next;
      rd_len_reg <= rd_len_next;
      wr_ptr_reg <= wr_ptr_next;
      wr_len_reg <= wr_len_next;
      rd_busy_reg <= rd_busy_next;
      wr_busy_reg <= wr_busy_next;
      rd_abort_reg <= rd_abort_next;
      wr_abort_reg <= wr_abort_next;
      rd_asm_reg <= rd_asm_next;
      rd_asm_full_reg <= rd_asm_full_next;
      wr_buf_reg <= wr_buf_next;
      wr_buf_valid_reg <= wr_buf_valid_next;
      pend_reg <= pend_next;
      pend_wr_reg <= pend_wr_next;
      pend_lane_reg <= pend_lane_next;
      core_req_reg <= core_req_next;
      core_we_reg <= core_we_next;
      core_addr_reg <= core_addr_next;
      core_wdata_reg <= core_wdata_next;
      host_rdata_reg <= host_rdata_next;
      host_rvalid_reg <= host_rvalid_next;
    end
  end

  assign HOST_RDATA = host_rdata_reg;
  assign HOST_RVALID = host_rvalid_reg;
  assign CORE_REQ = core_req_reg;
  assign CORE_WE = core_we_reg;
  assign CORE_ADDR = core_addr_reg;
  assign CORE_WDATA = core_wdata_reg;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence rd_start_s;
    rd_cmd_wr && HOST_WDATA[CMD_BUSY_BIT] && !HOST_WDATA[CMD_ABORT_BIT] && !rd_busy_reg;
  endsequence
  sequence rd_cancel_s;
    rd_cmd_wr && HOST_WDATA[CMD_ABORT_BIT];
  endsequence
  rd_start_busy_a: assert property (rd_start_s |=> rd_busy_reg)
    else $error("read start did not raise busy");
  // A second abort write right behind the first legally keeps the bit up one more cycle.
  rd_cancel_a: assert property (rd_cancel_s |=>
    !rd_busy_reg && rd_level == '0 && rd_abort_reg ##1 (!rd_abort_reg || $past(rd_cancel)))
    else $error("read abort did not clear busy, fifo and itself");
  rd_zero_cmd_a: assert property (rd_cmd_wr && HOST_WDATA[31:30] == 2'h0 &&
    rd_busy_reg && rd_len_reg != '0 |=> rd_busy_reg)
    else $error("writing zero to read command changed busy");
  rd_len_step_a: assert property (rd_ack && !rd_al_wr |=>
    rd_len_reg == $past(rd_len_reg) - 16'h0001 && rd_ptr_reg == $past(rd_ptr_reg) + 16'h0001)
    else $error("read length or address did not step");
  rd_count_a: assert property (rd_asm_full_reg && rd_in_ready && !rd_pop &&
    !rd_cancel |=> rd_level == $past(rd_level) + 5'h01 && rd_level != '0)
    else $error("read word count did not rise");
  rd_done_a: assert property (rd_busy_reg && rd_len_reg == '0 && !rd_asm_full_reg &&
    !pend_reg |=> !rd_busy_reg)
    else $error("read busy stayed after last byte");
  wr_len_step_a: assert property (wr_ack && !wr_al_wr |=>
    wr_len_reg == $past(wr_len_reg) - 16'h0001 && wr_ptr_reg == $past(wr_ptr_reg) + 16'h0001)
    else $error("write length or address did not step");
  wr_cancel_a: assert property (wr_cancel |=> !wr_busy_reg && wr_free == WR_FREE_RESET)
    else $error("write abort did not clear busy and fifo");
  wr_free_a: assert property (wr_push && wr_in_ready && !wr_pop && !wr_cancel |=>
    wr_free == $past(wr_free) - 5'h01)
    else $error("write free count did not fall");
  wr_start_busy_a: assert property (wr_start |=> wr_busy_reg)
    else $error("write start did not raise busy");
  cmd_reserved_a: assert property (HOST_RD && (HOST_ADDR == REG_RD_CMD ||
    HOST_ADDR == REG_WR_CMD) |=> HOST_RDATA[29:13] == '0 && HOST_RDATA[7:1] == '0)
    else $error("reserved command bits not zero");

endmodule

// File: tb/prf_core_model.sv
// Purpose: Behavioural model of the core process RAM byte port.
// Assumes: One request outstanding; the ack comes 1 to 4 cycles after the request.
// Notes: Read data toggle away from the last byte whenever no ack stands.
`timescale 1ns/1ps
module prf_core_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Byte port.
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [1:0] delay,
  output logic ack,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:4095];
  logic [2:0] wait_reg;
  logic busy_reg;
  logic we_reg;
  logic [11:0] idx_reg;
  logic [7:0] wd_reg;

  // Stale read data must not look valid, so the lines are inverted each cycle out of reset that brings no read ack.
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (rst) begin
      busy_reg <= 1'b0;
      wait_reg <= 3'h0;
      rdata <= 8'h5A;
    end else if (busy_reg) begin
      if (wait_reg == 3'h0) begin
        busy_reg <= 1'b0;
        ack <= 1'b1;
        if (we_reg) mem[idx_reg] <= wd_reg;
        else rdata <= mem[idx_reg];
      end else begin
        wait_reg <= wait_reg - 3'h1;
      end
    end else if (req) begin
      busy_reg <= 1'b1;
      wait_reg <= {1'b0, delay};
      we_reg <= we;
      idx_reg <= addr[11:0];
      wd_reg <= wdata;
    end
  end
endmodule

// File: tb/tb_prf_engine.sv
// Purpose: Self-checking bench for the process RAM transfer engine.
// Assumes: Host strobes are driven on the falling edge, one access at a time.
// Notes: Read answers are matched against a queue of noted expectations.
`timescale 1ns/1ps
module tb_prf_engine import prf_pkg::*; ();
  typedef struct packed {logic [31:0] d; logic [31:0] m;} prf_note_t;
  prf_note_t notes[$];
  logic sys_clk, rst, host_wr, host_rd, host_rvalid, core_req, core_we, core_ack;
  logic [HOST_AW-1:0] host_addr;
  logic [31:0] host_wdata, host_rdata;
  logic [CORE_AW-1:0] core_addr;
  logic [7:0] core_wdata, core_rdata;
  logic [1:0] core_dly;
  logic [31:0] lfsr_reg = 32'h00014A5D;
  int fail_count = 0;
  int n_checks = 0;

  prf_engine dut_u (.SYS_CLK(sys_clk), .RST(rst), .HOST_WR(host_wr), .HOST_RD(host_rd),
    .HOST_ADDR(host_addr), .HOST_WDATA(host_wdata), .HOST_RDATA(host_rdata),
    .HOST_RVALID(host_rvalid), .CORE_REQ(core_req), .CORE_WE(core_we),
    .CORE_ADDR(core_addr), .CORE_WDATA(core_wdata), .CORE_ACK(core_ack),
    .CORE_RDATA(core_rdata));
  prf_core_model core_u (.clk(sys_clk), .rst(rst), .req(core_req), .we(core_we),
    .addr(core_addr), .wdata(core_wdata), .delay(core_dly), .ack(core_ack),
    .rdata(core_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
    return lfsr_reg;
  endfunction

  function automatic logic [7:0] mb(input int i);
    return core_u.mem[i];
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic fail_out(input string msg);
    $display("mismatch at %0t: %s", $time, msg);
    fail_count++;
    end_of_test();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // All host accesses are whole aligned words, so no lane alignment issue arises.
  task automatic wr(input logic [HOST_AW-1:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    core_dly = 2'(rnd());
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(negedge sys_clk);
    host_wr = 1'b0;
  endtask

  task automatic rd(input logic [HOST_AW-1:0] a, input logic [31:0] e,
                    input logic [31:0] m, output logic [31:0] v);
    logic got;
    @(negedge sys_clk);
    notes.push_back({e, m});
    host_rd = 1'b1;
    host_addr = a;
    @(negedge sys_clk);
    host_rd = 1'b0;
    got = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (!got && host_rvalid === 1'b1) begin
        got = 1'b1;
        v = host_rdata;
      end
      if (!got) @(negedge sys_clk);
    end
    if (!got) fail_out("no read answer");
  endtask

  task automatic rd_exp(input logic [HOST_AW-1:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, e, 32'hFFFFFFFF, v);
  endtask

  task automatic poll(input logic [HOST_AW-1:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] v;
    for (int i = 0; i < 300; i++) begin
      rd(a, 32'h00000000, 32'h00000000, v);
      if ((v & m) === e) return;
    end
    fail_out("poll ran out");
  endtask

  always @(negedge sys_clk) begin
    if (host_rvalid === 1'b1) begin
      if (notes.size() == 0) begin
        fail_count++;
        $display("mismatch at %0t: unexpected answer", $time);
      end else if (notes[0].m != 32'h00000000) begin
        check(host_rdata & notes[0].m, notes[0].d);
        void'(notes.pop_front());
      end else begin
        void'(notes.pop_front());
      end
    end
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_out("run too long");
  end

  initial begin
    logic [31:0] v;
    logic [31:0] w [0:2];
    rst = 1'b1;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 10'h000;
    host_wdata = 32'h00000000;
    core_dly = 2'h0;
    for (int i = 0; i < 4096; i++) core_u.mem[i] = 8'(rnd());
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;

    rd_exp(REG_RD_ADDR_LEN, ADDR_LEN_RESET);
    rd_exp(REG_RD_CMD, 32'h00000000);
    rd_exp(REG_WR_ADDR_LEN, ADDR_LEN_RESET);
    rd_exp(REG_WR_CMD, 32'h00001001);
    wr(REG_RD_CMD, 32'h3FFFFFFE);
    wr(10'h200, 32'hFFFFFFFF);
    rd_exp(REG_RD_CMD, 32'h00000000);
    rd_exp(10'h200, 32'h00000000);
    wr(REG_WR_ADDR_LEN, 32'h12345678);
    rd_exp(REG_WR_ADDR_LEN, 32'h12345678);
    $display("test reset_and_access done");

    wr(REG_RD_ADDR_LEN, 32'h00061002);
    wr(REG_RD_CMD, 32'h80000000);
    poll(REG_RD_CMD, 32'h80000000, 32'h00000000);
    rd_exp(REG_RD_ADDR_LEN, 32'h00001008);
    rd_exp(REG_RD_CMD, 32'h00000201);
    rd_exp(10'h000, {mb(3), mb(2), 16'h0000});
    rd_exp(REG_RD_CMD, 32'h00000101);
    rd_exp(10'h000, {mb(7), mb(6), mb(5), mb(4)});
    rd_exp(REG_RD_CMD, 32'h00000000);
    rd_exp(10'h000, 32'h00000000);
    $display("test read_lanes done");

    wr(REG_RD_ADDR_LEN, 32'h00441100);
    wr(REG_RD_CMD, 32'h80000000);
    poll(REG_RD_CMD, 32'h00001F00, 32'h00001000);
    rd_exp(REG_RD_CMD, 32'h80001001);
    for (int i = 0; i < 17; i++) begin
      if (i == 16) poll(REG_RD_CMD, 32'h00000001, 32'h00000001);
      rd_exp(10'h000, {mb(259 + 4 * i), mb(258 + 4 * i),
        mb(257 + 4 * i), mb(256 + 4 * i)});
    end
    poll(REG_RD_CMD, 32'h80000000, 32'h00000000);
    rd_exp(REG_RD_CMD, 32'h00000000);
    $display("test read_fill_drain done");

    wr(REG_RD_ADDR_LEN, 32'h00C81200);
    wr(REG_RD_CMD, 32'h80000000);
    wr(REG_RD_CMD, 32'h00000000);
    rd(REG_RD_CMD, 32'h80000000, 32'h80000000, v);
    wr(REG_RD_CMD, 32'h40000000);
    poll(REG_RD_CMD, 32'h80000000, 32'h00000000);
    rd_exp(REG_RD_CMD, 32'h00000000);
    $display("test read_abort done");

    for (int i = 0; i < 3; i++) wr(10'h020, rnd());
    rd_exp(REG_WR_CMD, 32'h00000D01);
    for (int i = 3; i < 17; i++) wr(10'h020, rnd());
    rd_exp(REG_WR_CMD, 32'h00000000);
    wr(REG_WR_ADDR_LEN, 32'h00641300);
    wr(REG_WR_CMD, 32'h80000000);
    rd(REG_WR_CMD, 32'h80000000, 32'h80000000, v);
    wr(REG_WR_CMD, 32'h40000000);
    poll(REG_WR_CMD, 32'h80000000, 32'h00000000);
    rd_exp(REG_WR_CMD, 32'h00001001);
    $display("test write_full_abort done");

    for (int i = 0; i < 3; i++) begin
      w[i] = rnd();
      wr(10'h020, w[i]);
    end
    v = {16'h0000, mb(11), mb(0)};
    wr(REG_WR_ADDR_LEN, 32'h000A1001);
    wr(REG_WR_CMD, 32'h80000000);
    poll(REG_WR_CMD, 32'h80000000, 32'h00000000);
    rd_exp(REG_WR_ADDR_LEN, 32'h0000100B);
    rd_exp(REG_WR_CMD, 32'h00001001);
    for (int i = 1; i < 11; i++) begin
      check({24'h000000, mb(i)}, {24'h000000, w[i / 4][8 * (i % 4) +: 8]});
    end
    check({16'h0000, mb(11), mb(0)}, v);
    $display("test write_lanes done");
    end_of_test();
  end
endmodule
